// File: ugs_defs.vh
// Purpose: constants for the general status register bank
// Assumes: 100 MHz core clock
// Notes: command codes, field positions, reset values, timing counts
`ifndef UGS_DEFS_VH
`define UGS_DEFS_VH
// ==========================================================
// command codes
`define UGS_CMD_SCRATCH_WR 8'hB2
`define UGS_CMD_SCRATCH_RD 8'hB3
`define UGS_CMD_FRAME_RD 8'hB4
`define UGS_CMD_IDENT_RD 8'hB5
`define UGS_CMD_INTR_RD 8'hC0
// ==========================================================
// field layout and reset values
`define UGS_SCRATCH_MASK 16'h1FFF
`define UGS_SCRATCH_RST 16'h0000
`define UGS_FRAME_RST 11'h000
`define UGS_INTR_RST 32'h00000000
`define UGS_BIT_BUS_STATE 7
`define UGS_BIT_PSEUDO 5
`define UGS_BIT_SOF 4
`define UGS_BIT_DMA_END 3
`define UGS_BIT_SUSPEND 2
`define UGS_BIT_RESUME 1
`define UGS_BIT_BUS_RESET 0
`define UGS_EP_LSB 8
// identity byte and silicon version, values arbitrary
`define UGS_IDENT_BYTE 8'h5A
`define UGS_VERSION_BYTE 8'h01
// ==========================================================
// timing: pseudo frame period 1 ms at 100 MHz
`define UGS_FRAME_PERIOD_US 1000
`define UGS_CLK_MHZ 100
`define UGS_FRAME_CYCLES (`UGS_FRAME_PERIOD_US * `UGS_CLK_MHZ)
`define UGS_MISSED_LIMIT 2'd3
`endif

// File: ugs_regs.v
// Purpose: command-addressed scratch, frame, identity and interrupt source registers
// Assumes: bus strobes and event inputs are synchronous to core_clk
// Notes: a command phase selects the register, data phases follow
`timescale 1ns/1ps
`include "ugs_defs.vh"

// How it works
// - B2 writes scratch, B3 reads scratch
// - scratch bits 12..0 read/write, reset zero
// - B4 returns last good frame number
// - frame high bits 10..8, low 7..0
// - frame undefined after bus reset
// - B5 returns identity byte and version
// - C0 returns interrupt sources in two words
// - endpoints bits 23..8, upper byte zero
// - bit 7 shows live suspend state
// - bit 5 set by 1 ms pseudo frame
// - three missed frames enter suspend
// - bit 4 set on frame detected
// - bit 3 set on dma end
// - bit 2 set on awake-to-suspend change
// - bit 1 resume, bit 0 bus reset
// - per-endpoint flags set regardless of enable register, which gates irq_out only
module ugs_regs #(
    parameter FRAME_CYCLES = `UGS_FRAME_CYCLES
) (
    input wire core_clk,
    input wire rst_n,
    input wire bus_wr,
    input wire bus_rd,
    input wire command_data_select,
    input wire [15:0] bus_wdata,
    output reg [15:0] bus_rdata,
    output reg bus_rvalid,
    input wire sof_good,
    input wire [10:0] sof_frame,
    input wire dma_end,
    input wire bus_resume,
    input wire bus_reset,
    input wire bus_idle,
    input wire [15:0] endpoint_event,
    input wire [31:0] interrupt_enable_reg,
    output reg irq_out,
    output reg suspend_out
);
    // ==========================================================
    // command decoding
    // a command phase latches the code; every data phase after it works on
    // that code until the next command phase, so one command may be followed
    // by any number of data words. only the interrupt read counts its words.

    // bus state machine: one-hot, awake or suspended
    localparam [1:0] ST_AWAKE = 2'b01;
    localparam [1:0] ST_SUSPEND = 2'b10;
    // the live bus state bit is a status, never an interrupt request
    localparam [31:0] IRQ_MASK = ~(32'h00000001 << `UGS_BIT_BUS_STATE);

    // command register and word index of a two-word read
    reg [7:0] cmd_q;
    reg word_q;
    // register contents
    reg [15:0] scratch_q;
    reg [10:0] frame_q;
    reg [31:0] intr_q;
    reg [31:0] intr_d;
    // endpoint flags, next value per bit
    wire [15:0] ep_flag_d;
    // pseudo frame timer and missed frame count
    reg [16:0] tick_cnt_q;
    reg [1:0] missed_q;
    reg [1:0] missed_d;
    reg sof_seen_q;
    // bus state machine
    reg [1:0] bus_st_q;
    reg [1:0] bus_st_d;
    wire bus_suspended;
    // decoded strobes and events
    wire tick;
    wire rd_data;
    wire wr_data;
    wire wake_event;
    wire go_suspend;
    wire intr_done;

    // true when the latched command selects the given code
    function cmd_is;
        input [7:0] cmd;
        input [7:0] code;
        begin
            cmd_is = (cmd == code);
        end
    endfunction

    // half of the interrupt word picked by the word index
    function [15:0] intr_half;
        input [31:0] itr;
        input word;
        begin
            if (word)
                intr_half = itr[31:16];
            else
                intr_half = itr[15:0];
        end
    endfunction

    // read data for the latched command; unknown codes read as zero
    function [15:0] read_mux;
        input [7:0] cmd;
        input word;
        input [15:0] scr;
        input [10:0] frm;
        input [31:0] itr;
        begin
            case (cmd)
                `UGS_CMD_SCRATCH_RD: read_mux = scr;
                `UGS_CMD_FRAME_RD: read_mux = {5'h00, frm};
                `UGS_CMD_IDENT_RD: read_mux = {`UGS_IDENT_BYTE, `UGS_VERSION_BYTE};
                `UGS_CMD_INTR_RD: read_mux = intr_half(itr, word);
                default: read_mux = 16'h0000;
            endcase
        end
    endfunction

    // data phase strobes; reads with the select high are ignored
    assign rd_data = bus_rd && !command_data_select;
    assign wr_data = bus_wr && !command_data_select;
    // timer reaches its last count once per pseudo frame
    assign tick = (tick_cnt_q == FRAME_CYCLES - 1);
    // any sign of life on the bus ends or prevents suspend
    assign wake_event = sof_good || bus_resume || bus_reset || !bus_idle;
    assign bus_suspended = bus_st_q[1];
    // third missed frame in a row while the bus stays idle
    assign go_suspend = tick && !wake_event && !bus_suspended && (missed_q == `UGS_MISSED_LIMIT - 2'd1);
    // second word of an interrupt read closes the read
    assign intr_done = rd_data && cmd_is(cmd_q, `UGS_CMD_INTR_RD) && word_q;

    // ==========================================================
    // command phase capture and word counter
    // the upper byte of a command word is ignored; a new command always
    // restarts the word index, so an aborted two-word read cannot leave the
    // next interrupt read pointing at its upper half
    always @(posedge core_clk) begin
        if (!rst_n) begin
            cmd_q <= 8'h00;
            word_q <= 1'b0;
        end else if (bus_wr && command_data_select) begin
            cmd_q <= bus_wdata[7:0];
            word_q <= 1'b0;
        end else if (rd_data && cmd_is(cmd_q, `UGS_CMD_INTR_RD)) begin
            word_q <= ~word_q;
        end
    end

    // scratch register
    // reserved upper bits are masked on write so they always read as zero,
    // even when firmware breaks the rule and writes ones there
    always @(posedge core_clk) begin
        if (!rst_n)
            scratch_q <= `UGS_SCRATCH_RST;
        else if (wr_data && cmd_is(cmd_q, `UGS_CMD_SCRATCH_WR))
            scratch_q <= bus_wdata & `UGS_SCRATCH_MASK;
    end

    // frame number from last good start-of-frame
    // a bus reset leaves the old number in place: the value is meaningless
    // until the next good frame, and firmware must not rely on it
    always @(posedge core_clk) begin
        if (!rst_n)
            frame_q <= `UGS_FRAME_RST;
        else if (sof_good)
            frame_q <= sof_frame;
    end

    // 1 ms pseudo frame timer and missed frame count
    // the timer restarts on every good frame, so it only reaches its last
    // count when an expected frame is missing; three such ticks in a row
    // with an idle bus put the bus state machine into suspend
    always @(posedge core_clk) begin
        if (!rst_n || sof_good)
            tick_cnt_q <= 17'd0;
        else if (tick)
            tick_cnt_q <= 17'd0;
        else
            tick_cnt_q <= tick_cnt_q + 17'd1;
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            missed_q <= 2'd0;
            sof_seen_q <= 1'b0;
            bus_st_q <= ST_AWAKE;
        end else begin
            missed_q <= missed_d;
            sof_seen_q <= sof_good;
            bus_st_q <= bus_st_d;
        end
    end

    // missed frame count: cleared by bus activity, saturates at the limit
    always @* begin
        missed_d = missed_q;
        if (wake_event)
            missed_d = 2'd0;
        else if (tick && missed_q != `UGS_MISSED_LIMIT)
            missed_d = missed_q + 2'd1;
    end

    // bus state machine: enter suspend on the third missed frame,
    // leave it on any frame, resume, reset or bus activity
    always @* begin
        case (bus_st_q)
            ST_AWAKE: begin
                if (go_suspend)
                    bus_st_d = ST_SUSPEND;
                else
                    bus_st_d = ST_AWAKE;
            end
            ST_SUSPEND: begin
                if (wake_event)
                    bus_st_d = ST_AWAKE;
                else
                    bus_st_d = ST_SUSPEND;
            end
            default: bus_st_d = ST_AWAKE;
        endcase
    end

    // endpoint flags: one sticky flag per endpoint, set wins over read clear
    genvar ep;
    generate
        for (ep = 0; ep < 16; ep = ep + 1) begin : g_ep_flag
            assign ep_flag_d[ep] = (intr_q[`UGS_EP_LSB + ep] && !intr_done) || endpoint_event[ep];
        end
    endgenerate

    // interrupt sources: sticky events, set wins over read clear
    always @* begin
        intr_d = intr_done ? `UGS_INTR_RST : intr_q;
        intr_d[23:8] = ep_flag_d;
        if (tick)
            intr_d[`UGS_BIT_PSEUDO] = 1'b1;
        if (sof_seen_q)
            intr_d[`UGS_BIT_SOF] = 1'b1;
        if (dma_end)
            intr_d[`UGS_BIT_DMA_END] = 1'b1;
        if (go_suspend)
            intr_d[`UGS_BIT_SUSPEND] = 1'b1;
        if (bus_resume)
            intr_d[`UGS_BIT_RESUME] = 1'b1;
        if (bus_reset)
            intr_d[`UGS_BIT_BUS_RESET] = 1'b1;
        intr_d[`UGS_BIT_BUS_STATE] = bus_suspended;
        intr_d[6] = 1'b0;
        intr_d[31:24] = 8'h00;
    end

    always @(posedge core_clk) begin
        if (!rst_n)
            intr_q <= `UGS_INTR_RST;
        else
            intr_q <= intr_d;
    end

    // ==========================================================
    // outputs
    // read answer: data and its valid pulse one cycle after the data read;
    // the data word stands until the next data read
    always @(posedge core_clk) begin
        if (!rst_n) begin
            bus_rdata <= 16'h0000;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rvalid <= rd_data;
            if (rd_data)
                bus_rdata <= read_mux(cmd_q, word_q, scratch_q, frame_q, intr_q);
        end
    end

    // interrupt request: any enabled flag; the live bus state bit never requests.
    // the next flag value is used so a flag and its request appear together
    always @(posedge core_clk) begin
        if (!rst_n)
            irq_out <= 1'b0;
        else
            irq_out <= |(intr_d & interrupt_enable_reg & IRQ_MASK);
    end

    // suspend state as seen from outside
    always @(posedge core_clk) begin
        if (!rst_n)
            suspend_out <= 1'b0;
        else
            suspend_out <= bus_suspended;
    end
endmodule

// File: ugs_properties.sv
// Purpose: answer checks for the general status register bank
// Assumes: one core_clk domain, sync active-low reset
// Notes: tracks the last command code and the word index
`timescale 1ns/1ps
`include "ugs_defs.vh"
module ugs_properties (
    input wire core_clk, input wire rst_n, input wire bus_wr, input wire bus_rd,
    input wire command_data_select, input wire [15:0] bus_wdata, input wire [15:0] bus_rdata,
    input wire bus_rvalid, input wire bus_idle, input wire sof_good, input wire suspend_out
);
    reg [7:0] cmd_q;
    reg idx_q;
    wire drd = bus_rd & ~command_data_select;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // command and word tracking
    always @(posedge core_clk) begin
        if (!rst_n || (bus_wr && command_data_select)) begin
            cmd_q <= rst_n ? bus_wdata[7:0] : 8'h00;
            idx_q <= 1'b0;
        end else if (drd) begin
            idx_q <= ~idx_q;
        end
    end
    // ==========================================================
    // properties
    property p_ans; drd |=> bus_rvalid; endproperty
    a_ans: assert property (p_ans) else $error("data read got no answer");
    property p_quiet; !drd |=> !bus_rvalid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without data read");
    property p_id; drd && cmd_q == `UGS_CMD_IDENT_RD |=> bus_rdata == {`UGS_IDENT_BYTE, `UGS_VERSION_BYTE}; endproperty
    a_id: assert property (p_id) else $error("identity word wrong");
    property p_scr; drd && cmd_q == `UGS_CMD_SCRATCH_RD |=> bus_rdata[15:13] == 3'h0; endproperty
    a_scr: assert property (p_scr) else $error("scratch reserved bits set");
    property p_frm; drd && cmd_q == `UGS_CMD_FRAME_RD |=> bus_rdata[15:11] == 5'h00; endproperty
    a_frm: assert property (p_frm) else $error("frame reserved bits set");
    property p_top; drd && cmd_q == `UGS_CMD_INTR_RD && idx_q |=> bus_rdata[15:8] == 8'h00; endproperty
    a_top: assert property (p_top) else $error("interrupt top byte set");
    property p_sus; $rose(suspend_out) |-> $past(bus_idle, 2); endproperty
    a_sus: assert property (p_sus) else $error("suspend with bus active");
    property p_wake; sof_good |-> ##[1:2] !suspend_out; endproperty
    a_wake: assert property (p_wake) else $error("frame did not wake bus");
    c_intr: cover property (drd && cmd_q == `UGS_CMD_INTR_RD && idx_q);
    c_id: cover property (drd && cmd_q == `UGS_CMD_IDENT_RD);
    c_sus: cover property ($rose(suspend_out));
endmodule
bind ugs_regs ugs_properties u_props (.*);

// File: ugs_host.sv
// Purpose: microprocessor model on the command/data bus
// Assumes: strobes launched at the rising edge
// Notes: released data lines show the inverse of the last word
`timescale 1ns/1ps
module ugs_host (
    input wire core_clk,
    input wire [15:0] bus_rdata,
    input wire bus_rvalid,
    output reg bus_wr = 1'b0,
    output reg bus_rd = 1'b0,
    output reg command_data_select = 1'b0,
    output reg [15:0] bus_wdata = 16'h0000
);
    // one word write, command phase when s is high
    task wr(input s, input [15:0] d);
        @(posedge core_clk);
        bus_wr <= 1'b1;
        command_data_select <= s;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        bus_wdata <= ~d;
    endtask
    // one word data read, unknown if no answer
    task rd(output [15:0] d);
        @(posedge core_clk);
        bus_rd <= 1'b1;
        command_data_select <= 1'b0;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rvalid ? bus_rdata : 16'hxxxx;
    endtask
    // command phase then first data word
    task get(input [7:0] c, output [15:0] d);
        wr(1'b1, {8'h00, c});
        rd(d);
    endtask
endmodule

// File: testbench.sv
// Purpose: self-checking bench for ugs_regs
// Assumes: pseudo frame shortened to 50 cycles
// Notes: one task per scenario
`timescale 1ns/1ps
`include "ugs_defs.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; $display("BAD %s %h %h", n, e, s); end end
module testbench;
    reg core_clk = 1'b0, rst_n = 1'b0, sof_good = 1'b0, dma_end = 1'b0, bus_resume = 1'b0, bus_reset = 1'b0;
    reg bus_idle = 1'b0;
    reg [10:0] sof_frame = 11'h000;
    reg [15:0] endpoint_event = 16'h0000, d;
    reg [31:0] interrupt_enable_reg = 32'h00000000;
    wire bus_wr, bus_rd, command_data_select, bus_rvalid, irq_out, suspend_out;
    wire [15:0] bus_wdata, bus_rdata;
    int err_total = 0, checked = 0, i;
    ugs_host host (.*);
    ugs_regs #(.FRAME_CYCLES(50)) dut (.*);
    // event pulse: k is reset, resume, dma end, frame
    task pulse(input [3:0] k, input [15:0] e);
        @(posedge core_clk);
        {bus_reset, bus_resume, dma_end, sof_good} <= k;
        endpoint_event <= e;
        @(posedge core_clk);
        {bus_reset, bus_resume, dma_end, sof_good} <= 4'h0;
        endpoint_event <= 16'h0000;
    endtask
    task t_regs;
        host.get(`UGS_CMD_SCRATCH_RD, d); `CHK("scr0", 16'h0000, d)
        host.wr(1'b1, {8'hFF, `UGS_CMD_SCRATCH_WR});
        host.wr(1'b0, 16'h1ABC);
        host.get(`UGS_CMD_SCRATCH_RD, d); `CHK("scr", 16'h1ABC, d)
        host.wr(1'b1, {8'h00, `UGS_CMD_SCRATCH_RD});
        host.wr(1'b0, 16'h0123);
        host.rd(d); `CHK("nowr", 16'h1ABC, d)
        host.get(8'h77, d); `CHK("unk", 16'h0000, d)
        sof_frame <= 11'h7A5;
        pulse(4'h1, 16'h0000);
        host.get(`UGS_CMD_FRAME_RD, d); `CHK("frame", 16'h07A5, d)
        host.get(`UGS_CMD_IDENT_RD, d); `CHK("ident", 16'h5A01, d)
        $display("regs done");
    endtask
    task t_intr;
        pulse(4'hE, 16'hFFFF);
        repeat (2) @(posedge core_clk);
        #1 `CHK("irq off", 1'b0, irq_out)
        interrupt_enable_reg <= 32'hFFFFFF7F;
        repeat (2) @(posedge core_clk);
        #1 `CHK("irq on", 1'b1, irq_out)
        host.get(`UGS_CMD_INTR_RD, d); `CHK("lo", 16'hFF1B, d & 16'hFFDF)
        host.rd(d); `CHK("hi", 16'h00FF, d)
        host.get(`UGS_CMD_INTR_RD, d); `CHK("lo2", 16'h0000, d & 16'hFFDF)
        host.rd(d); `CHK("hi2", 16'h0000, d)
        $display("intr done");
    endtask
    task t_susp;
        pulse(4'h1, 16'h0000);
        bus_idle <= 1'b1;
        repeat (140) @(posedge core_clk);
        `CHK("early", 1'b0, suspend_out)
        for (i = 0; i < 40 && suspend_out !== 1'b1; i++) @(posedge core_clk);
        `CHK("susp", 1'b1, suspend_out)
        if (suspend_out !== 1'b1) summarize();
        host.get(`UGS_CMD_INTR_RD, d); `CHK("sflag", 16'h00A4, d & 16'h00A4)
        host.rd(d);
        pulse(4'h1, 16'h0000);
        host.get(`UGS_CMD_INTR_RD, d); `CHK("awake", 16'h0000, d & 16'h0080)
        host.rd(d);
        $display("susp done");
    endtask
    task summarize;
        $display("checked %0d bad %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial forever #5 core_clk = ~core_clk;
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs;
        t_intr;
        t_susp;
        summarize;
    end
    initial begin
        #1000000 err_total++;
        summarize;
    end
endmodule
